// ===== common/pixel_link_rx_pkg.sv
// shared constants and types for the pixel link receiver output side
`default_nettype none
package pixel_link_rx_pkg;
    // reference clock rate, in kHz
    localparam int CLK_KHZ = 20000;
    // downstream sideband per-pin rate ceilings, in kbit/s
    localparam int SB_FULL_KBPS = 13890;
    localparam int SB_HALF_KBPS = 6940;
    // least sideband clock period in cycles, rounded up so the rate stays below the ceiling
    localparam int SB_FULL_CYC = (CLK_KHZ + SB_FULL_KBPS - 1) / SB_FULL_KBPS;
    localparam int SB_HALF_CYC = (CLK_KHZ + SB_HALF_KBPS - 1) / SB_HALF_KBPS;
    // upstream line clock choices, in kHz
    localparam logic [16:0] UP_LINE0_KHZ = 17'h0F424;
    localparam logic [16:0] UP_LINE1_KHZ = 17'h0A28A;
    localparam logic [16:0] UP_LINE2_KHZ = 17'h07A12;
    localparam logic [16:0] UP_LINE3_KHZ = 17'h0515E;
    // sampling is one third of the line clock; one slot in sixteen is skipped
    localparam int UP_DIV = 3;
    localparam logic [16:0] UP_THRESH = 17'(UP_DIV * CLK_KHZ);
    localparam logic [3:0] UP_SKIP_SLOT = 4'hF;
    // pixel bus layout
    localparam int PIX_W = 24;
    localparam int CTRL_LINE_SYNC = 0;
    localparam int CTRL_FRAME_SYNC = 1;
    localparam int CTRL_VALID = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int PX_HALF_CYC = 4;
    typedef enum logic [1:0] {W10 = 2'h0, W12 = 2'h1, W18 = 2'h2, W24 = 2'h3} width_type;
    typedef enum logic [1:0] {CM_NEVER = 2'h0, CM_EVEN = 2'h1, CM_EACH = 2'h2} ctrl_mode_type;
    typedef enum logic [3:0] {
        ST_WAIT = 4'h1, ST_G1 = 4'h2, ST_G2 = 4'h4, ST_G3 = 4'h8
    } phase_type;
    typedef struct packed {
        logic bw_half;
        width_type width;
        ctrl_mode_type ctrl_mode;
        logic launch_falling;
        logic [1:0] up_clk_sel;
        logic up_separate_pair;
    } cfg_type;
    localparam cfg_type CFG_RESET = '{1'b0, W24, CM_EACH, 1'b0, 2'h0, 1'b0};
    typedef struct packed {
        logic [2:0] ctrl;
        logic [PIX_W-1:0] data;
    } pixel_word_type;
    typedef struct packed {
        logic valid;
        logic [1:0] bits;
    } down_sb_type;
endpackage
`default_nettype wire

// ===== rtl/pixel_link_receiver_ports.sv
// pixel bus, sideband pins and upstream sampler of the link receiver, with its pixel fifo
// What the document requires
// [RULE_01] downstream runs in full 1 GBit/s or half 500 MBit/s bandwidth mode
// [RULE_02] net video payload is 847 Mbit/s full, 423.6 Mbit/s half
// [RULE_03] pixels and sideband share the link; sideband uses reserved low-latency slots
// [RULE_04] upstream uses common-mode on shared pair or differential on second pair
// [RULE_05] upstream rate comes from configuration, independent of the signalling path
// [RULE_06] parallel pixel data up to 24 bits, synchronous to pixel clock, max 62 MHz
// [RULE_07] pixel width 10, 12, 18 or 24 bits, packed from bit zero
// [RULE_08] control bits: 0 line sync, 1 frame sync, 2 data valid
// [RULE_09] control sent never, on even pixels, or each pixel
// [RULE_10] pixel outputs in four groups, three switching at staggered offsets
// [RULE_11] launch edge of pixel data selectable rising or falling
// [RULE_12] width and control mode come from loaded configuration
// [RULE_13] downstream sideband on two pins, synchronous to its own clock output
// [RULE_14] sideband pin rate below 13.89 Mbit/s full, 6.94 Mbit/s half
// [RULE_15] both upstream inputs sampled together, sent as one 2-bit packet
// [RULE_16] upstream sampling runs at one third of the upstream line clock; at 62.5 MHz it is capped at one sample per cycle
// [RULE_17] every sixteenth sampling cycle is skipped for link framing
// [RULE_18] line clock 62.5, 41.61, 31.25 or 20.83 MHz selectable
// [RULE_19] active-high error output on pixel clock or link sync error
// [RULE_20] active-low reset returns all logic to its initial state
// [RULE_21] upstream inputs synchronised before capture
// [RULE_22] source holds each upstream value longer than the sampling jitter
`default_nettype none
module pixel_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic ready;
    } fifo_state_type;
    fifo_state_type st, next_st;
    logic push, pop;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("fifo depth must be a power of two of at least 2");
        end
    end

    // ready and empty both come from registered state
    assign push = i_in_valid && st.ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_in_ready = st.ready;
    assign o_out_valid = (st.count != '0);
    assign o_out_data = st.mem[st.rptr];

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = i_in_data;
            next_st.wptr = st.wptr + AW'(1);
        end
        if (pop) begin
            next_st.rptr = st.rptr + AW'(1);
        end
        next_st.count = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
        next_st.ready = (next_st.count != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            st <= '0;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule

module pixel_link_receiver_ports
    import pixel_link_rx_pkg::*;
#(
    parameter int PX_HALF = PX_HALF_CYC,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire cfg_type i_cfg,
    input wire pixel_word_type i_pixel_word,
    input wire logic i_pixel_valid,
    output logic o_pixel_ready,
    input wire down_sb_type i_down_sb,
    input wire logic [1:0] i_up_sideband_in,
    input wire logic i_pixel_clock_error,
    input wire logic i_link_sync_error,
    output logic [PIX_W-1:0] o_pixel_data_out,
    output logic [2:0] o_pixel_control_out,
    output logic o_pixel_clock_out,
    output logic [1:0] o_down_sideband_out,
    output logic o_down_sideband_clock,
    output logic [1:0] o_upstream_serial_out,
    output logic o_upstream_packet_valid,
    output logic o_up_common_mode,
    output logic o_link_half_rate,
    output logic o_rx_error
);
    localparam int PXW = $clog2(PX_HALF + 1);
    localparam int SBW = $clog2(SB_HALF_CYC + 1);

    // four stagger phases must fit inside one half period of the pixel clock
    initial begin
        if (PX_HALF < 4 || DEPTH < 2) begin
            $error("pixel half period below 4 cycles or fifo too shallow");
        end
    end

    typedef struct packed {
        cfg_type act;
        logic [PXW-1:0] px_cnt;
        logic pclk;
        logic odd;
        pixel_word_type word;
        phase_type phase;
        logic [PIX_W-1:0] data;
        logic [2:0] ctrl;
        logic [SBW-1:0] sb_cnt;
        logic sb_clk;
        logic [1:0] sb_out;
        down_sb_type sb_pend;
        logic [1:0] up_meta;
        logic [1:0] up_sync;
        logic [16:0] up_acc;
        logic [3:0] up_frame;
        logic [1:0] up_pkt;
        logic up_valid;
        logic err;
    } state_type;

    state_type st, next_st;
    logic launch, up_tick, pclk_flip, sb_start;
    logic [16:0] up_sum;
    pixel_word_type fifo_word;
    logic fifo_valid;

    function automatic logic [PIX_W-1:0] width_mask(input width_type w);
        case (w)
            W10: width_mask = 24'h0003FF;
            W12: width_mask = 24'h000FFF;
            W18: width_mask = 24'h03FFFF;
            default: width_mask = 24'hFFFFFF;
        endcase
    endfunction

    // [RULE_18] line clock choice
    function automatic logic [16:0] line_khz(input logic [1:0] sel);
        case (sel)
            2'h0: line_khz = UP_LINE0_KHZ;
            2'h1: line_khz = UP_LINE1_KHZ;
            2'h2: line_khz = UP_LINE2_KHZ;
            default: line_khz = UP_LINE3_KHZ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pixel word buffer; drained only at pixel rate, so a burst from the link fills it
    pixel_fifo #(
        .WIDTH($bits(pixel_word_type)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_in_data(i_pixel_word),
        .i_in_valid(i_pixel_valid),
        .o_in_ready(o_pixel_ready),
        .o_out_data(fifo_word),
        .o_out_valid(fifo_valid),
        .i_out_ready(launch)
    );

    // enables derived from registered counters
    assign pclk_flip = (st.px_cnt == PXW'(PX_HALF - 1));
    // [RULE_11] launch edge select
    assign launch = pclk_flip && (st.pclk == st.act.launch_falling);
    assign sb_start = (st.sb_cnt == '0);
    // [RULE_16] line tick accumulator, one third
    assign up_sum = st.up_acc + line_khz(st.act.up_clk_sel);
    assign up_tick = (up_sum >= UP_THRESH);

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        // pixel clock divider, the only pixel-side timebase
        next_st.px_cnt = pclk_flip ? '0 : st.px_cnt + PXW'(1);
        if (pclk_flip) begin
            next_st.pclk = !st.pclk;
        end
        // [RULE_12] settings reloaded at each pixel launch
        if (launch) begin
            next_st.act = i_cfg;
            next_st.odd = !st.odd;
            // [RULE_07] width mask from bit zero
            next_st.word.data = fifo_word.data & width_mask(i_cfg.width);
            next_st.word.ctrl = fifo_word.ctrl;
            // an empty buffer gives an idle pixel, not stale valid
            if (!fifo_valid) begin
                next_st.word.ctrl[CTRL_VALID] = 1'b0;
            end
            // [RULE_10] group zero on the launch edge
            next_st.data[7:0] = next_st.word.data[7:0];
            next_st.phase = ST_G1;
        end else begin
            // [RULE_10] staggered groups one to three
            case (st.phase)
                ST_G1: begin
                    next_st.data[15:8] = st.word.data[15:8];
                    next_st.phase = ST_G2;
                end
                ST_G2: begin
                    next_st.data[23:16] = st.word.data[23:16];
                    next_st.phase = ST_G3;
                end
                ST_G3: begin
                    // [RULE_09] control transmit mode
                    case (st.act.ctrl_mode)
                        CM_NEVER: next_st.ctrl = 3'h0;
                        CM_EVEN: next_st.ctrl = st.odd ? st.word.ctrl : st.ctrl;
                        default: next_st.ctrl = st.word.ctrl;
                    endcase
                    next_st.phase = ST_WAIT;
                end
                default: next_st.phase = ST_WAIT;
            endcase
        end
        // [RULE_14] sideband period sized from bandwidth mode
        if (sb_start) begin
            next_st.sb_cnt = st.act.bw_half ? SBW'(SB_HALF_CYC - 1) : SBW'(SB_FULL_CYC - 1);
        end else begin
            next_st.sb_cnt = st.sb_cnt - SBW'(1);
        end
        // [RULE_13] data changes with the rising sideband clock
        next_st.sb_clk = sb_start;
        // [RULE_03] slot bits held until the next sideband period
        if (sb_start && st.sb_pend.valid) begin
            next_st.sb_out = st.sb_pend.bits;
            next_st.sb_pend.valid = 1'b0;
        end
        // new slot wins over the clear
        if (i_down_sb.valid) begin
            next_st.sb_pend = i_down_sb;
        end
        // [RULE_21] two-flop synchroniser
        next_st.up_meta = i_up_sideband_in;
        next_st.up_sync = st.up_meta;
        next_st.up_valid = 1'b0;
        if (up_tick) begin
            // a sum past two thresholds clears the accumulator: top rate caps at one sample per cycle
            next_st.up_acc = up_sum - UP_THRESH;
            if (next_st.up_acc >= UP_THRESH) begin
                next_st.up_acc = '0;
            end
            next_st.up_frame = st.up_frame + 4'h1;
            // [RULE_17] framing slot skipped
            if (st.up_frame != UP_SKIP_SLOT) begin
                // [RULE_15] both bits in one packet
                next_st.up_pkt = st.up_sync;
                next_st.up_valid = 1'b1;
            end
        end else begin
            next_st.up_acc = up_sum;
        end
        // [RULE_19] error flag
        next_st.err = i_pixel_clock_error || i_link_sync_error;
    end

    // [RULE_20] reset to initial state
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            st <= '0;
            st.act <= CFG_RESET;
            st.phase <= ST_WAIT;
        end else begin
            st <= next_st;
        end
    end

    // [RULE_08] control bit order kept from word
    assign o_pixel_data_out = st.data;
    assign o_pixel_control_out = st.ctrl;
    assign o_pixel_clock_out = st.pclk;
    assign o_down_sideband_out = st.sb_out;
    assign o_down_sideband_clock = st.sb_clk;
    assign o_upstream_serial_out = st.up_pkt;
    assign o_upstream_packet_valid = st.up_valid;
    // [RULE_04] path flag; [RULE_05] rate ignores it
    assign o_up_common_mode = !st.act.up_separate_pair;
    // [RULE_01] bandwidth mode exported to link
    // [RULE_02] payload rate follows this mode; the link side budgets it
    assign o_link_half_rate = st.act.bw_half;
    assign o_rx_error = st.err;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    property p_rx_error;
        (i_pixel_clock_error || i_link_sync_error) |=> o_rx_error;
    endproperty
    a_rx_error: assert property (p_rx_error) else $error("error input not reported"); // [RULE_19]

    property p_stagger;
        launch |=> st.phase == ST_G1 ##1 st.phase == ST_G2 ##1 st.phase == ST_G3
            ##1 st.phase == ST_WAIT;
    endproperty
    a_stagger: assert property (p_stagger) else $error("group stagger out of order"); // [RULE_10]

    property p_width;
        st.phase == ST_G3 |-> (o_pixel_data_out & ~width_mask(st.act.width)) == '0;
    endproperty
    a_width: assert property (p_width) else $error("pixel bits above width set"); // [RULE_07]

    property p_ctrl_never;
        (st.phase == ST_G3 && st.act.ctrl_mode == CM_NEVER) |=> o_pixel_control_out == 3'h0;
    endproperty
    a_ctrl_never: assert property (p_ctrl_never) else $error("control sent in never mode"); // [RULE_09]

    property p_pclk_half;
        $changed(o_pixel_clock_out) |=> $stable(o_pixel_clock_out)[*3];
    endproperty
    a_pclk_half: assert property (p_pclk_half) else $error("pixel clock half period short"); // [RULE_06]

    property p_launch_edge;
        launch |=> o_pixel_clock_out == !$past(st.act.launch_falling);
    endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("data launched on wrong edge"); // [RULE_11]

    property p_sb_half;
        ($rose(o_down_sideband_clock) && $past(o_link_half_rate))
            |=> !o_down_sideband_clock [*2];
    endproperty
    a_sb_half: assert property (p_sb_half) else $error("sideband rate too high in half mode"); // [RULE_14]

    property p_sb_data;
        !o_down_sideband_clock |-> $stable(o_down_sideband_out);
    endproperty
    a_sb_data: assert property (p_sb_data) else $error("sideband data moved off clock"); // [RULE_13]

    property p_up_skip;
        (up_tick && st.up_frame == UP_SKIP_SLOT) |=> !o_upstream_packet_valid;
    endproperty
    a_up_skip: assert property (p_up_skip) else $error("framing slot not skipped"); // [RULE_17]

    property p_up_pkt;
        (up_tick && st.up_frame != UP_SKIP_SLOT) |=>
            o_upstream_packet_valid && o_upstream_serial_out == $past(st.up_sync);
    endproperty
    a_up_pkt: assert property (p_up_pkt) else $error("upstream sample lost"); // [RULE_15]
endmodule
`default_nettype wire

// ===== verif/link_tx_model.sv
// stand-in for the remote link transmitter: pixel word source and downstream sideband slots
`default_nettype none
module link_tx_model
    import pixel_link_rx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ready,
    output var pixel_word_type o_word,
    output var logic o_valid,
    output var down_sb_type o_sb
);
    timeunit 1ns;
    timeprecision 1ns;
    pixel_word_type q[$];
    initial begin
        o_word = '0;
        o_valid = 1'b0;
        o_sb = '0;
    end
    // pixel words share the link with sideband slots
    always @(posedge i_clk) begin
        if (o_valid && i_ready && q.size() != 0) begin
            void'(q.pop_front());
        end
    end
    // request held until taken; idle lines toggle so stale data never looks valid
    always @(negedge i_clk) begin
        o_valid <= (q.size() != 0);
        o_word <= (q.size() != 0) ? q[0] : ~o_word;
    end
    task automatic send(input pixel_word_type w);
        q.push_back(w);
    endtask
    // withdraw whatever is still waiting, used after a refusal and before the mid-run reset
    task automatic drop();
        q.delete();
    endtask
    task automatic slot(input logic [1:0] b);
        @(negedge i_clk);
        o_sb <= '{1'b1, b};
        @(negedge i_clk);
        o_sb <= '{1'b0, ~b};
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the pixel link receiver output side
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tb
    import pixel_link_rx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // slow pixel clock so sixteen words fit between two launches
    localparam int PXH = 16;
    typedef struct packed {
        logic half, sep;
        logic [1:0] sel;
        logic pce, lse;
        logic [1:0] up;
        logic err;
        int cnt;
    } row_type;
    // packets in 960 cycles: line rate / 3, capped at one per cycle, less one slot in sixteen
    row_type rows[4] = '{
        '{1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h1, 1'b0, 32'h384},
        '{1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 2'h2, 1'b1, 32'h270},
        '{1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 2'h3, 1'b1, 32'h1D4},
        '{1'b1, 1'b0, 2'h3, 1'b1, 1'b1, 2'h0, 1'b1, 32'h138}};
    logic [23:0] masks[4] = '{24'h0003FF, 24'h000FFF, 24'h03FFFF, 24'hFFFFFF};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    cfg_type cfg = CFG_RESET;
    logic pce = 1'b0, lse = 1'b0, pvalid, pready, pclk, sbclk, pkt, cm, hr, err;
    logic [1:0] up = 2'h0, sbo, ser;
    logic [23:0] pd;
    logic [2:0] pc, oc;
    pixel_word_type word;
    down_sb_type sb;
    int n_errors = 0, compares = 0, lc = 0, n = 0, bad = 0;
    always #25 clk = ~clk;
    always @(posedge pclk) lc++;
    pixel_link_receiver_ports #(.PX_HALF(PXH), .DEPTH(FIFO_DEPTH)) i_dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg), .i_pixel_word(word),
        .i_pixel_valid(pvalid), .o_pixel_ready(pready), .i_down_sb(sb),
        .i_up_sideband_in(up), .i_pixel_clock_error(pce), .i_link_sync_error(lse),
        .o_pixel_data_out(pd), .o_pixel_control_out(pc), .o_pixel_clock_out(pclk),
        .o_down_sideband_out(sbo), .o_down_sideband_clock(sbclk),
        .o_upstream_serial_out(ser), .o_upstream_packet_valid(pkt),
        .o_up_common_mode(cm), .o_link_half_rate(hr), .o_rx_error(err));
    link_tx_model i_model (.i_clk(clk), .i_ready(pready), .o_word(word), .o_valid(pvalid),
        .o_sb(sb));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic done(input string nm);
        $display("test %s done: %0d compares, %0d mismatches", nm, compares, n_errors);
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic rst_check(input int c);
        rst_b = 1'b0;
        cyc(c);
        `CHK("reset outputs", 36'h0, {pd, pc, pclk, sbo, sbclk, ser, pkt, hr, err})
        `CHK("reset cm ready", 2'h3, {cm, pready})
        rst_b = 1'b1;
        lc = 0;
        done("reset");
    endtask
    task automatic wait_launch();
        @(posedge pclk);
        cyc(1);
    endtask
    // bounded wait for the next sideband clock pulse
    task automatic wait_sb();
        @(negedge clk);
        for (int k = 0; k < 9 && sbclk !== 1'b1; k++) @(negedge clk);
    endtask
    // follows one launch; bytes land a cycle apart, control last
    task automatic show(input logic [23:0] d, input logic [2:0] c, input bit known,
                        input bit fall, input bit cchk);
        logic [23:0] od, e;
        od = pd;
        oc = pc;
        if (fall) begin
            @(negedge pclk);
        end else begin
            @(posedge pclk);
        end
        for (int k = 1; k <= 4; k++) begin
            @(negedge clk);
            e = {(k > 2) ? d[23:16] : od[23:16], (k > 1) ? d[15:8] : od[15:8], d[7:0]};
            if (known || k == 4) `CHK("pixel data", e, pd)
            if (cchk && (known || k == 4)) `CHK("pixel ctrl", (k == 4) ? c : oc, pc)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_check(20);
        // table rows: configuration, error inputs and upstream sampling
        foreach (rows[i]) begin
            @(negedge clk);
            cfg.bw_half = rows[i].half;
            cfg.up_separate_pair = rows[i].sep;
            cfg.up_clk_sel = rows[i].sel;
            {pce, lse, up} = {rows[i].pce, rows[i].lse, rows[i].up};
            cyc(6 * PXH + 4);
            `CHK("error flag", rows[i].err, err)
            `CHK("half rate", rows[i].half, hr)
            `CHK("common mode", ~rows[i].sep, cm)
            n = 0;
            bad = 0;
            // pins held far longer than the sampling jitter
            repeat (960) begin
                @(negedge clk);
                if (pkt === 1'b1) begin
                    n++;
                    bad += (ser !== up);
                end
            end
            `CHK("packet rate", 1'b1, (n >= rows[i].cnt - 2 && n <= rows[i].cnt + 2))
            `CHK("packet bits", 0, bad)
            done("table row");
        end
        {pce, lse} = 2'h0;
        cfg = CFG_RESET;
        // every pixel width, packed from bit zero
        for (int w = 0; w < 4; w++) begin
            cfg.width = width_type'(w);
            wait_launch();
            i_model.send('{3'h5, 24'hD6B5A7});
            show(24'hD6B5A7 & masks[w], 3'h5, 1'b0, 1'b0, 1'b1);
            `CHK("masked pixel", 24'hD6B5A7 & masks[w], pd)
        end
        done("widths");
        cfg.ctrl_mode = CM_NEVER;
        wait_launch();
        i_model.send('{3'h7, 24'h123456});
        show(24'h123456, 3'h0, 1'b0, 1'b0, 1'b0);
        `CHK("ctrl never", 3'h0, pc)
        // even mode: only odd-numbered launches since reset refresh control
        cfg.ctrl_mode = CM_EVEN;
        wait_launch();
        i_model.send('{3'h5, 24'h0A0B0C});
        i_model.send('{3'h2, 24'h0D0E0F});
        show(24'h0A0B0C, 3'h0, 1'b0, 1'b0, 1'b0);
        if (lc % 2 == 1) `CHK("ctrl even", 3'h5, pc)
        oc = pc;
        show(24'h0D0E0F, 3'h0, 1'b1, 1'b0, 1'b0);
        `CHK("ctrl even", (lc % 2 == 1) ? 3'h2 : oc, pc)
        done("ctrl modes");
        // fill past capacity between two launches, then drain in order
        cfg.ctrl_mode = CM_EACH;
        wait_launch();
        for (int i = 0; i < 17; i++) i_model.send('{i[2:0], 24'h102030 + 24'(i)});
        cyc(20);
        `CHK("fifo full", 1'b0, pready)
        i_model.drop();
        for (int i = 0; i < 16; i++) show(24'h102030 + 24'(i), i[2:0], i > 0, 1'b0, 1'b1);
        `CHK("fifo ready", 1'b1, pready)
        // an idle launch re-shows the word under the read pointer, with valid low
        show(24'h102030, 3'h0, 1'b1, 1'b0, 1'b0);
        `CHK("idle valid", 1'b0, pc[CTRL_VALID])
        done("fifo");
        // launch on the falling pixel clock edge
        cfg.launch_falling = 1'b1;
        wait_launch();
        wait_launch();
        i_model.send('{3'h3, 24'h5A5A5A});
        show(24'h5A5A5A, 3'h3, 1'b0, 1'b1, 1'b1);
        @(posedge pclk);
        cyc(4);
        `CHK("rising edge hold", 24'h5A5A5A, pd)
        cfg.launch_falling = 1'b0;
        done("launch edge");
        // sideband clock period and slot delivery, full then half bandwidth
        for (int h = 0; h < 2; h++) begin
            cfg.bw_half = h[0];
            cyc(6 * PXH);
            wait_sb();
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (sbclk !== 1'b1 && n < 9);
            `CHK("sideband period", h ? SB_HALF_CYC : SB_FULL_CYC, n)
            i_model.slot(2'h1 + h[1:0]);
            // the first pulse may come from a period that began before the slot
            wait_sb();
            wait_sb();
            `CHK("sideband bits", 2'h1 + h[1:0], sbo)
        end
        done("sideband");
        // reset in mid-run with words queued and half rate active
        for (int i = 0; i < 3; i++) i_model.send('{3'h4, 24'hABCDEF});
        cyc(5);
        i_model.drop();
        cyc(1);
        rst_check(2);
        results();
    end
    // watchdog well beyond the expected run of about 5600 cycles
    initial begin
        #(20000 * 50);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        results();
    end
endmodule
`default_nettype wire
